// >>> rtl/ctf_pkg.sv
package ctf_pkg;

    // ==========================================================
    // register map (byte offsets, 8-bit data)
    // ==========================================================
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  A_CTRL0     = 8'h00;
    localparam logic [7:0]  A_CTRL1     = 8'h01;
    localparam logic [7:0]  A_BT0       = 8'h02;
    localparam logic [7:0]  A_BT1       = 8'h03;
    localparam logic [7:0]  A_RXFLG     = 8'h04;
    localparam logic [7:0]  A_RXIEN     = 8'h05;
    localparam logic [7:0]  A_TXFLG     = 8'h06;
    localparam logic [7:0]  A_TXCTL     = 8'h07;
    localparam logic [7:0]  A_ACC       = 8'h08;
    localparam logic [7:0]  A_RXERR     = 8'h09;
    localparam logic [7:0]  A_TXERR     = 8'h0A;
    localparam logic [7:0]  A_PAT_BASE  = 8'h10;
    localparam logic [7:0]  A_MASK_BASE = 8'h18;
    localparam logic [7:0]  A_RX_FOREGROUND_BUFFER_BASE = 8'h20;
    localparam logic [7:0]  A_TXB_BASE  = 8'h40;

    // ==========================================================
    // message layout
    // ==========================================================
    localparam int unsigned FRAME_BYTES = 13;
    localparam logic [3:0]  LOCAL_PRIORITY_IDX    = 4'hD;
    localparam int unsigned NUM_TXB     = 3;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int unsigned SOFTRST_BIT = 0;
    localparam int unsigned SLPRQ_BIT   = 1;
    localparam int unsigned SLPAK_BIT   = 2;
    localparam int unsigned RXF_BIT     = 0;
    localparam int unsigned OVR_BIT     = 1;
    localparam int unsigned BOFF_BIT    = 2;
    localparam int unsigned TERR_BIT    = 3;
    localparam int unsigned RERR_BIT    = 4;
    localparam int unsigned TWRN_BIT    = 5;
    localparam int unsigned RWRN_BIT    = 6;
    localparam int unsigned WUP_BIT     = 7;
    localparam int unsigned ABAK_LSB    = 4;
    localparam int unsigned MODE_LSB    = 4;

    // ==========================================================
    // reset values and limits
    // ==========================================================
    localparam logic [7:0]  CTRL0_RST     = 8'h01;
    localparam logic [8:0]  WARN_LIMIT    = 9'h060;
    localparam logic [8:0]  PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0]  BUS_OFF_STATE_LIMIT  = 9'h0FF;

    // filter modes
    localparam logic [1:0]  MODE_WIDE   = 2'h0;
    localparam logic [1:0]  MODE_16     = 2'h1;
    localparam logic [1:0]  MODE_8      = 2'h2;
    localparam logic [1:0]  MODE_CLOSED = 2'h3;

    // ==========================================================
    // carriers
    // ==========================================================
    // byte 0..3 identifier registers, 4..11 data, 12 length
    typedef struct packed {
        logic [FRAME_BYTES-1:0][7:0] b;
    } ctf_frame_t;

    typedef struct packed {
        logic       valid;
        ctf_frame_t frame;
    } ctf_rx_t;

    typedef struct packed {
        logic [1:0] sel;
        ctf_frame_t frame;
    } ctf_tx_t;

endpackage

// >>> rtl/ctf_core.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// [R1] three tx buffers, 13 bytes, 8-bit priority
// [R2] host loads buffer then clears empty flag
// [R3] sent buffer sets empty flag, tx interrupt
// [R4] arbitration picks lowest priority value
// [R5] abort grants ack, empty, interrupt
// [R6] ack reads one only when aborted
// [R7] wide mode: two full 32-bit filters
// [R8] 16-bit mode: four half filters
// [R9] 8-bit mode: eight byte filters
// [R10] closed mode never accepts anything
// [R11] pattern registers, mask makes don't care
// [R12] accept sets full flag, lowest hit index
// [R13] eleven sources on four vectors
// [R14] receive interrupt right after end of frame
// [R15] bus activity in sleep sets wakeup flag
// [R16] warning flags at error count 96
// [R17] passive flags above 127
// [R18] bus-off flag above 255
// [R19] write-one clears, blocked while condition persists
// [R20] error counters read only
// [R21] config registers writable only in soft reset
// [R22] transmit pin recessive in low power
// [R23] copy background to foreground when flag clear
// [R24] both buffers full: discard, set overrun
// [R25] mask bit one means don't care
module ctf_core (
    input  wire logic                       clk,          // 100 MHz module clock
    input  wire logic                       reset,        // async, active high
    input  wire logic [ctf_pkg::ADDR_W-1:0] addr,         // register address
    input  wire logic [7:0]                 wdata,        // write data
    input  wire logic                       wr,           // write strobe
    input  wire logic                       rd,           // read strobe
    output logic      [7:0]                 rdata,        // read data, cycle after rd
    input  wire logic                       core_arb,     // engine arbitrates now
    input  wire logic                       core_tx_busy, // selected buffer on the bus
    input  wire logic                       core_tx_done, // selected buffer sent ok
    output logic                            tx_pending,   // some buffer scheduled
    output ctf_pkg::ctf_tx_t                tx_out,       // chosen buffer and frame
    input  wire ctf_pkg::ctf_rx_t           core_rx,      // frame at end of frame
    input  wire logic                       core_rx_busy, // engine is receiving
    input  wire logic                       core_tx_bit,  // engine transmit level
    input  wire logic                       bus_rx_pin,   // bus receive pin
    output logic                            bus_tx_pin,   // bus transmit pin
    input  wire logic [7:0]                 rx_err_cnt,   // receive error count
    input  wire logic [8:0]                 tx_err_cnt,   // transmit error count
    input  wire logic                       power_down,   // clocks about to stop
    output logic                            core_run,     // engine may run
    output logic      [15:0]                bit_timing,   // timing for the engine
    output logic      [7:0]                 module_ctrl1, // second control register
    output logic                            irq_wakeup,   // wake-up vector
    output logic                            irq_error,    // error vector
    output logic                            irq_rx,       // receive vector
    output logic                            irq_tx        // transmit vector
);
    import ctf_pkg::*;

    // ==========================================================
    // helpers
    // ==========================================================
    // masked byte compare, mask bit set means don't care
    function automatic logic byte_match(input logic [7:0] id, input logic [7:0] pat,
                                        input logic [7:0] msk);
        byte_match = ((id ^ pat) & ~msk) == 8'h00; // R11 R25
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    logic [7:0] module_control_reg0;
    logic [7:0] bit_timing_reg0, bit_timing_reg1;
    logic [7:0] rx_flag_reg;
    logic [7:0] rx_int_enable_reg;
    logic [2:0] tx_buffer_empty_flag;
    logic [2:0] abort_acknowledge;
    logic [2:0] abort_request;
    logic [2:0] tx_empty_int_enable;
    logic [1:0] filter_mode;
    logic [2:0] filter_hit_index;
    logic [7:0] accept_pattern_regs [8], accept_mask_regs [8];
    logic [7:0] tx_mem [NUM_TXB][FRAME_BYTES+1];
    ctf_frame_t rx_background_buffer, rx_foreground_buffer;
    logic       bg_full;
    logic [2:0] bg_hit;
    logic       rx_meta, rx_sync;

    // ==========================================================
    // decode
    // ==========================================================
    wire soft_reset_bit = module_control_reg0[SOFTRST_BIT];
    wire sleep_ack      = module_control_reg0[SLPAK_BIT];
    wire sleep_req      = module_control_reg0[SLPRQ_BIT];
    wire low_power      = sleep_ack | soft_reset_bit | power_down;
    wire wr_ctrl0       = wr && addr == A_CTRL0;
    wire wr_cfg         = wr && soft_reset_bit; // R21
    wire wr_rxflg       = wr && addr == A_RXFLG;
    wire wr_txflg       = wr && addr == A_TXFLG;
    wire wr_txctl       = wr && addr == A_TXCTL;
    wire wr_filt        = wr_cfg && addr[7:4] == A_PAT_BASE[7:4];
    wire wr_txb         = wr && addr[7:6] == A_TXB_BASE[7:6] && addr[5:4] != 2'h3
                          && addr[3:0] <= LOCAL_PRIORITY_IDX;
    wire [1:0] txb_sel  = addr[5:4];

    // ==========================================================
    // acceptance filter
    // ==========================================================
    logic [7:0]      hit;
    wire  [3:0][7:0] eq_id; // identifier byte, then slot
    // per-slot compares against each identifier byte
    genvar g, k;
    generate
        for (g = 0; g < 8; g++) begin : g_cmp
            for (k = 0; k < 4; k++) begin : g_byte
                assign eq_id[k][g] = byte_match(core_rx.frame.b[k], accept_pattern_regs[g], accept_mask_regs[g]);
            end
        end
    endgenerate
    // hits per mode, slot order follows bank then byte
    always_comb begin
        hit = 8'h00;
        case (filter_mode)
            MODE_WIDE: begin
                hit[0] = eq_id[0][0] & eq_id[1][1] & eq_id[2][2] & eq_id[3][3]; // R7
                hit[1] = eq_id[0][4] & eq_id[1][5] & eq_id[2][6] & eq_id[3][7]; // R7
            end
            MODE_16: begin
                hit[0] = eq_id[0][0] & eq_id[1][1]; // R8
                hit[1] = eq_id[0][2] & eq_id[1][3];
                hit[2] = eq_id[0][4] & eq_id[1][5];
                hit[3] = eq_id[0][6] & eq_id[1][7];
            end
            MODE_8:  hit = eq_id[0]; // R9
            default: hit = 8'h00; // R10
        endcase
    end
    // lowest-numbered filter wins
    logic [2:0] hit_idx;
    always_comb begin
        hit_idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = 3'(i); // R12
            end
        end
    end
    wire accepted   = core_rx.valid && |hit;
    wire overrun    = accepted && bg_full && rx_flag_reg[RXF_BIT]; // R24
    wire bg_store   = accepted && !overrun;
    // copy is held off while asleep, done once awake
    wire do_copy    = bg_full && !rx_flag_reg[RXF_BIT] && !sleep_ack; // R23

    // ==========================================================
    // receive buffers
    // ==========================================================
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bg_full <= 1'b0;
            bg_hit  <= 3'h0;
        end else begin
            bg_full <= bg_store | (bg_full & ~do_copy);
            if (bg_store) begin
                bg_hit <= hit_idx;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (bg_store) begin
            rx_background_buffer <= core_rx.frame;
        end
        if (do_copy) begin
            rx_foreground_buffer <= rx_background_buffer; // R23
        end
    end

    // ==========================================================
    // receive/error flags
    // ==========================================================
    // hardware set beats a same-cycle write-one clear
    logic [7:0] flag_set;
    wire        wake_seen = sleep_ack && !rx_sync; // R15
    always_comb begin
        flag_set           = 8'h00;
        flag_set[RXF_BIT]  = do_copy; // R12 R14
        flag_set[OVR_BIT]  = overrun; // R24
        flag_set[BOFF_BIT] = tx_err_cnt > BUS_OFF_STATE_LIMIT; // R18
        flag_set[TERR_BIT] = tx_err_cnt > PASSIVE_LIMIT; // R17
        flag_set[RERR_BIT] = {1'b0, rx_err_cnt} > PASSIVE_LIMIT; // R17
        flag_set[TWRN_BIT] = tx_err_cnt >= WARN_LIMIT; // R16
        flag_set[RWRN_BIT] = {1'b0, rx_err_cnt} >= WARN_LIMIT; // R16
        flag_set[WUP_BIT]  = wake_seen; // R15
    end
    // level sources re-set every cycle, so a clear cannot stick
    wire [7:0] flag_clr  = wr_rxflg ? wdata : 8'h00;
    wire [7:0] next_flag = flag_set | (rx_flag_reg & ~flag_clr); // R19

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_flag_reg      <= 8'h00;
            filter_hit_index <= 3'h0;
        end else begin
            rx_flag_reg <= next_flag;
            if (do_copy) begin
                filter_hit_index <= bg_hit; // R12
            end
        end
    end

    // ==========================================================
    // control and configuration
    // ==========================================================
    // sleep request cannot be withdrawn before the ack
    wire slp_clr_ok = !wdata[SLPRQ_BIT] && sleep_ack;
    wire next_slprq = wake_seen ? 1'b0 :
                      wr_ctrl0 ? (wdata[SLPRQ_BIT] | (sleep_req & ~slp_clr_ok)) : sleep_req;
    // sleep entered once all buffers empty and receiver idle
    wire next_slpak = next_slprq && !soft_reset_bit && !wake_seen
                      && (sleep_ack || (&tx_buffer_empty_flag && !core_rx_busy));
    wire next_srst  = wr_ctrl0 ? wdata[SOFTRST_BIT] : soft_reset_bit;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            module_control_reg0 <= CTRL0_RST;
        end else begin
            module_control_reg0 <= {5'h00, next_slpak, next_slprq, next_srst};
        end
    end
    // locked configuration registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            module_ctrl1    <= 8'h00;
            bit_timing_reg0 <= 8'h00;
            bit_timing_reg1 <= 8'h00;
            filter_mode     <= MODE_WIDE;
        end else if (wr_cfg) begin
            if (addr == A_CTRL1) module_ctrl1 <= wdata; // R21
            if (addr == A_BT0) bit_timing_reg0 <= wdata;
            if (addr == A_BT1) bit_timing_reg1 <= wdata;
            if (addr == A_ACC) filter_mode <= wdata[MODE_LSB+1:MODE_LSB];
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                accept_pattern_regs[i] <= 8'h00;
                accept_mask_regs[i]    <= 8'h00;
            end
        end else if (wr_filt) begin
            if (addr[3]) begin
                accept_mask_regs[addr[2:0]] <= wdata; // R11
            end else begin
                accept_pattern_regs[addr[2:0]] <= wdata; // R11
            end
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_int_enable_reg   <= 8'h00;
            tx_empty_int_enable <= 3'h0;
        end else begin
            if (wr && addr == A_RXIEN) rx_int_enable_reg <= wdata;
            if (wr_txctl) tx_empty_int_enable <= wdata[2:0];
        end
    end

    // ==========================================================
    // transmit buffers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (wr_txb) begin
            tx_mem[txb_sel][addr[3:0]] <= wdata; // R1
        end
    end
    // lowest priority value wins, ties go to lower index
    logic [1:0] best_sel;
    logic       best_ok;
    always_comb begin
        best_sel = 2'h0;
        best_ok  = 1'b0;
        for (int i = 0; i < NUM_TXB; i++) begin
            if (!tx_buffer_empty_flag[i] &&
                (!best_ok || tx_mem[i][LOCAL_PRIORITY_IDX] < tx_mem[best_sel][LOCAL_PRIORITY_IDX])) begin
                best_sel = 2'(i); // R4
                best_ok  = 1'b1;
            end
        end
    end
    // chosen at every arbitration, also after an error
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_out <= '0;
        end else if (core_arb && best_ok) begin
            tx_out.sel <= best_sel; // R4
            for (int j = 0; j < FRAME_BYTES; j++) begin
                tx_out.frame.b[j] <= tx_mem[best_sel][j];
            end
        end
    end
    // per-buffer empty, abort request and acknowledge
    generate
        for (g = 0; g < NUM_TXB; g++) begin : g_txb
            wire on_bus   = core_tx_busy && tx_out.sel == 2'(g);
            wire sent     = core_tx_done && tx_out.sel == 2'(g) && !tx_buffer_empty_flag[g];
            // a frame on the bus cannot be pulled back
            wire aborted  = abort_request[g] && !tx_buffer_empty_flag[g] && !on_bus
                            && !sleep_ack && !sent; // R5
            wire schedule = wr_txflg && wdata[g] && tx_buffer_empty_flag[g]; // R2
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    tx_buffer_empty_flag[g] <= 1'b1;
                    abort_acknowledge[g]    <= 1'b0;
                    abort_request[g]        <= 1'b0;
                end else begin
                    if (sent || aborted) begin
                        tx_buffer_empty_flag[g] <= 1'b1; // R3 R5
                    end else if (schedule) begin
                        tx_buffer_empty_flag[g] <= 1'b0; // R2
                    end
                    if (aborted) begin
                        abort_acknowledge[g] <= 1'b1; // R6
                    end else if (schedule || sent) begin
                        abort_acknowledge[g] <= 1'b0; // R6
                    end
                    if (sent || aborted) begin
                        abort_request[g] <= 1'b0;
                    end else if (wr_txctl && wdata[ABAK_LSB+g]) begin
                        abort_request[g] <= 1'b1; // R5
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // pin and engine control
    // ==========================================================
    // two-stage sync of the receive pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= bus_rx_pin;
            rx_sync <= rx_meta;
        end
    end

    assign bus_tx_pin = low_power ? 1'b1 : core_tx_bit; // R22
    assign core_run   = !low_power;
    assign bit_timing = {bit_timing_reg1, bit_timing_reg0};
    assign tx_pending = |(~tx_buffer_empty_flag);

    // ==========================================================
    // interrupt vectors
    // ==========================================================
    assign irq_wakeup = rx_flag_reg[WUP_BIT] & rx_int_enable_reg[WUP_BIT]; // R13 R15
    assign irq_error  = |(rx_flag_reg[RWRN_BIT:OVR_BIT] & rx_int_enable_reg[RWRN_BIT:OVR_BIT]); // R13
    assign irq_rx     = rx_flag_reg[RXF_BIT] & rx_int_enable_reg[RXF_BIT]; // R14
    assign irq_tx     = |(tx_buffer_empty_flag & tx_empty_int_enable); // R3

    // ==========================================================
    // read path
    // ==========================================================
    logic [7:0] rd_value;
    always_comb begin
        rd_value = 8'h00;
        if (addr[7:6] == A_TXB_BASE[7:6] && addr[5:4] != 2'h3 && addr[3:0] <= LOCAL_PRIORITY_IDX) begin
            rd_value = tx_mem[txb_sel][addr[3:0]];
        end else if (addr[7:4] == A_RX_FOREGROUND_BUFFER_BASE[7:4] && addr[3:0] < 4'(FRAME_BYTES)) begin
            rd_value = rx_foreground_buffer.b[addr[3:0]];
        end else if (addr[7:4] == A_PAT_BASE[7:4]) begin
            rd_value = addr[3] ? accept_mask_regs[addr[2:0]] : accept_pattern_regs[addr[2:0]];
        end else begin
            case (addr)
                A_CTRL0: rd_value = module_control_reg0;
                A_CTRL1: rd_value = module_ctrl1;
                A_BT0:   rd_value = bit_timing_reg0;
                A_BT1:   rd_value = bit_timing_reg1;
                A_RXFLG: rd_value = rx_flag_reg;
                A_RXIEN: rd_value = rx_int_enable_reg;
                A_TXFLG: rd_value = {1'b0, abort_acknowledge, 1'b0, tx_buffer_empty_flag};
                A_TXCTL: rd_value = {1'b0, abort_request, 1'b0, tx_empty_int_enable};
                A_ACC:   rd_value = {2'h0, filter_mode, 1'b0, filter_hit_index};
                A_RXERR: rd_value = rx_err_cnt; // R20
                A_TXERR: rd_value = tx_err_cnt[7:0]; // R20
                default: rd_value = 8'h00;
            endcase
        end
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? rd_value : 8'h00;
        end
    end

endmodule

// >>> sim/ctf_core_assertions.sv
`timescale 1ns/10ps
// ==========================================
// port-level checks of the message core
module ctf_core_chk (
    input wire logic clk, reset, wr, rd, core_arb, tx_pending, bus_tx_pin, power_down, core_run, // watched
    input wire logic [7:0] addr, rdata, rx_err_cnt, // bus side
    input wire logic [15:0] bit_timing, // timing
    input wire ctf_pkg::ctf_tx_t tx_out // chosen frame
);
    import ctf_pkg::*;
    // one domain
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_pin_pwrdown: assert property (power_down |-> bus_tx_pin)
        else $error("tx pin dominant in power down");
    chk_pin_offline: assert property (!core_run |-> bus_tx_pin)
        else $error("tx pin dominant offline");
    chk_run_halted: assert property (power_down |-> !core_run)
        else $error("engine runs in power down");
    chk_cnt_readback: assert property (rd && addr == A_RXERR |=> rdata == $past(rx_err_cnt))
        else $error("error count readback");
    chk_timing_lock: assert property (wr && core_run && (addr == A_BT0 || addr == A_BT1) |=> $stable(bit_timing))
        else $error("timing changed online");
    chk_out_hold: assert property (!core_arb |=> tx_out === $past(tx_out))
        else $error("tx frame changed unarbitrated");
    chk_arb_empty: assert property (core_arb && !tx_pending |=> tx_out === $past(tx_out))
        else $error("tx frame changed when idle");
    chk_sel_range: assert property (core_arb && tx_pending |=> tx_out.sel != 2'h3)
        else $error("buffer out of range");
endmodule
bind ctf_core ctf_core_chk i_ctf_core_chk (.*);

// >>> sim/ctf_bus_model.sv
`timescale 1ns/10ps
// ==========================================
// protocol engine and bus stand-in
module ctf_bus_model (
    input  wire logic       clk,          // module clock
    output logic            core_arb,     // arbitration pulse
    output logic            core_tx_busy, // frame on the wire
    output logic            core_tx_done, // frame sent
    output ctf_pkg::ctf_rx_t core_rx,     // frame at end of frame
    output logic            core_rx_busy, // receiving
    output logic            core_tx_bit,  // engine level
    output logic            bus_rx_pin,   // recessive when idle
    output logic [7:0]      rx_err_cnt,   // receive errors
    output logic [8:0]      tx_err_cnt    // transmit errors
);
    // dominant only while a frame is on the wire
    assign core_tx_bit = !core_tx_busy;
    initial {core_arb, core_tx_busy, core_tx_done, core_rx, core_rx_busy, rx_err_cnt, tx_err_cnt} = '0;
    initial bus_rx_pin = 1'b1;
    // arbitrate, hold the wire three cycles, report success
    task automatic send();
        @(posedge clk);
        core_arb <= 1'b1;
        @(posedge clk);
        core_arb     <= 1'b0;
        core_tx_busy <= 1'b1;
        repeat (3) @(posedge clk);
        core_tx_busy <= 1'b0;
        core_tx_done <= 1'b1;
        @(posedge clk);
        core_tx_done <= 1'b0;
    endtask
    // invert a stale frame rather than hold it
    task automatic recv(input logic [3:0][7:0] id);
        @(posedge clk);
        core_rx.valid        <= 1'b1;
        core_rx.frame.b[3:0] <= id;
        @(posedge clk);
        core_rx.valid <= 1'b0;
        core_rx.frame <= ~core_rx.frame;
    endtask
endmodule

// >>> sim/ctf_core_tb.sv
`timescale 1ns/10ps
// ==========================================
// bench top
module ctf_core_tb;
    import ctf_pkg::*;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, power_down = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, f, rx_err_cnt, module_ctrl1;
    logic core_arb, core_tx_busy, core_tx_done, tx_pending, core_rx_busy, core_tx_bit, bus_rx_pin, bus_tx_pin;
    logic core_run, irq_wakeup, irq_error, irq_rx, irq_tx;
    logic [8:0] tx_err_cnt;
    logic [15:0] bit_timing;
    ctf_tx_t tx_out;
    ctf_rx_t core_rx;
    logic [7:0] pat [8] = '{8'h12, 8'h34, 8'h56, 8'h70, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk [8] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    int err_count = 0, num_checks = 0;
    always #5 clk = ~clk;
    ctf_core i_ctf_core (.*);
    ctf_bus_model i_ctf_bus_model (.*);
    // ==========================================
    // shared helpers
    task automatic check(input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // settle past the edge
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 f = rdata;
    endtask
    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_config();
        rd_reg(A_CTRL0);
        check(f, CTRL0_RST);
        check(bus_tx_pin, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'(A_PAT_BASE + i), pat[i]);
            wr_reg(8'(A_MASK_BASE + i), msk[i]);
        end
        wr_reg(A_ACC, 8'h00);
        wr_reg(A_BT0, 8'h3C);
        wr_reg(A_CTRL0, 8'h00);
        wr_reg(A_BT0, 8'h5A);
        check(bit_timing[7:0], 8'h3C);
    endtask
    // hits on both banks, then an overrun
    task automatic t_filter();
        wr_reg(A_RXIEN, 8'h03);
        i_ctf_bus_model.recv({8'h7A, 8'h56, 8'h34, 8'h12});
        repeat (3) @(posedge clk);
        rd_reg(A_ACC);
        check(f[2:0], 3'h0);
        check(irq_rx, 1'b1);
        i_ctf_bus_model.recv({8'h88, 8'h56, 8'h34, 8'h12});
        i_ctf_bus_model.recv({8'h88, 8'h56, 8'h34, 8'h12});
        repeat (3) @(posedge clk);
        rd_reg(A_RXFLG);
        check(f[1:0], 2'h3);
        wr_reg(A_RXFLG, 8'h03);
        rd_reg(A_ACC);
        check(f[2:0], 3'h1);
        check(irq_error, 1'b0);
    endtask
    task automatic t_tx();
        wr_reg(A_TXB_BASE + 8'h0D, 8'h1E);
        wr_reg(A_TXB_BASE + 8'h1D, 8'h0A);
        wr_reg(A_TXB_BASE + 8'h10, 8'hA5);
        wr_reg(A_TXB_BASE + 8'h2D, 8'h14);
        wr_reg(A_TXCTL, 8'h07);
        check(irq_tx, 1'b1);
        wr_reg(A_TXFLG, 8'h07);
        check({irq_tx, tx_pending}, 2'h1);
        i_ctf_bus_model.send();
        check(tx_out.sel, 2'h1);
        check(tx_out.frame.b[0], 8'hA5);
        rd_reg(A_TXFLG);
        check(f, 8'h02);
        check(irq_tx, 1'b1);
        wr_reg(A_TXCTL, 8'h17);
        repeat (2) @(posedge clk);
        rd_reg(A_TXFLG);
        check(f, 8'h13);
        i_ctf_bus_model.send();
        i_ctf_bus_model.send();
        check(tx_out.sel, 2'h2);
    endtask
    // error thresholds, level flags
    task automatic t_errors();
        wr_reg(A_RXIEN, 8'h40);
        @(posedge clk);
        i_ctf_bus_model.rx_err_cnt <= 8'd96;
        i_ctf_bus_model.tx_err_cnt <= 9'd256;
        repeat (3) @(posedge clk);
        rd_reg(A_RXFLG);
        check(f[7:2], 6'b011011);
        check(irq_error, 1'b1);
        wr_reg(A_RXERR, 8'h00);
        rd_reg(A_RXERR);
        check(f, 8'd96);
        wr_reg(A_RXFLG, 8'h40);
        rd_reg(A_RXFLG);
        check(f[6], 1'b1);
        @(posedge clk);
        i_ctf_bus_model.rx_err_cnt <= 8'd95;
        wr_reg(A_RXFLG, 8'h40);
        rd_reg(A_RXFLG);
        check(f[6], 1'b0);
        @(posedge clk);
        power_down <= 1'b1;
        @(posedge clk);
        #1 check({bus_tx_pin, core_run}, 2'h2);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_config();
        t_filter();
        t_tx();
        t_errors();
        print_verdict();
    end
    // hang guard
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
endmodule
